/* File: fcm_board.sv */
// Board-side model that resolves the two-way pins
`timescale 1ns/1ps
module fcm_board (
  // Device side of the pins
  input  wire logic [9:0] dev_pin_in,
  input  wire logic [9:0] dev_oe_b_in,
  // Board drive request
  input  wire logic [9:0] drv_en_in,
  input  wire logic [9:0] drv_val_in,
  // Resolved wire level
  output logic      [9:0] pin_lvl_out
);
  // Device wins where it drives; an undriven pin floats to the inverse of
  // the board value so a stale level can never pass for a real one
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (!dev_oe_b_in[i]) pin_lvl_out[i] = dev_pin_in[i];
      else if (drv_en_in[i]) pin_lvl_out[i] = drv_val_in[i];
      else pin_lvl_out[i] = ~drv_val_in[i];
    end
  end
endmodule

/* File: fcm_macrocell.sv */
// Input capture cells and buried / pin output cells around a sum-of-products array
`timescale 1ns/1ps
module fcm_macrocell #(
  parameter int POWERUP_CYCLES = fcm_pkg::POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  // Register port
  input  wire logic [fcm_pkg::AW-1:0]   addr_in,
  input  wire logic [fcm_pkg::DW-1:0]   wr_data_in,
  input  wire logic                     wr_en_in,
  input  wire logic                     rd_en_in,
  output logic      [fcm_pkg::DW-1:0]   rd_data_out,
  // Capture and output clocks
  input  wire logic                     input_capture_clock_in,
  input  wire logic                     shared_output_clock_in,
  // Terms from the array
  input  wire logic [fcm_pkg::N_CELL-1:0] data_sum_in,
  input  wire logic [fcm_pkg::N_CELL-1:0] enable_sum_in,
  input  wire logic                     reset_term_in,
  input  wire logic [fcm_pkg::N_PIN-1:0]  oe_term_in,
  // Pins
  input  wire logic [fcm_pkg::N_DED-1:0]  ded_in,
  input  wire logic [fcm_pkg::N_PIN-1:0]  pin_in,
  output logic      [fcm_pkg::N_PIN-1:0]  pin_out,
  output logic      [fcm_pkg::N_PIN-1:0]  pin_oe_b_out,
  // Feedback to the array
  output logic      [fcm_pkg::N_DED-1:0]  dedicated_input_cell_out,
  output logic      [fcm_pkg::N_PIN-1:0]  pin_input_cell_out,
  output logic      [fcm_pkg::N_CELL-1:0] cell_fb_out
);
  import fcm_pkg::*;

  fcm_state_t r;
  fcm_state_t s;

  // Decoded modes and edges, shared by logic and checks
  logic [1:0]  ded_mode;
  logic [1:0]  pin_mode;
  logic        input_capture_clock_rise;
  logic        shared_output_clock_rise;
  logic [17:0] e_term;
  logic [17:0] d_term;
  logic [17:0] e_rise;

  // Each group has one mode; unused code 01 acts as pass-through
  assign ded_mode  = {r.in_cfg[IN_DED_HOLD], r.in_cfg[IN_DED_SYNC]};
  assign pin_mode  = {r.in_cfg[IN_PIN_HOLD], r.in_cfg[IN_PIN_SYNC]};
  assign input_capture_clock_rise = input_capture_clock_in & ~r.input_capture_clock_prev;
  assign shared_output_clock_rise = shared_output_clock_in & ~r.shared_output_clock_prev;

  // Polarity XORs; buried cells use the data term as it comes
  assign e_term = enable_sum_in ^ r.en_pol;
  assign d_term = data_sum_in ^ {8'h00, r.data_pol};
  assign e_rise = e_term & ~r.e_prev;

  // Next state of the whole block
  always_comb begin
    logic [1:0] md;
    s = r;
    md = 2'h0;
    s.input_capture_clock_prev = input_capture_clock_in;
    s.shared_output_clock_prev = shared_output_clock_in;
    s.e_prev = e_term;

    // Configuration writes
    if (wr_en_in) begin
      case (addr_in)
        ADDR_IN_CFG:   s.in_cfg = wr_data_in[3:0];
        ADDR_CLK_SRC:  s.clk_src = wr_data_in[17:0];
        ADDR_BYPASS:   s.bypass = wr_data_in[17:0];
        ADDR_DATA_POL: s.data_pol = wr_data_in[9:0];
        ADDR_EN_POL:   s.en_pol = wr_data_in[17:0];
        default:       s.in_cfg = r.in_cfg;
      endcase
    end

    // Read data stand for one cycle only; unmapped reads give zero
    s.rd_data = 32'h0000_0000;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_IN_CFG:   s.rd_data = {28'h000_0000, r.in_cfg};
        ADDR_CLK_SRC:  s.rd_data = {14'h0000, r.clk_src};
        ADDR_BYPASS:   s.rd_data = {14'h0000, r.bypass};
        ADDR_DATA_POL: s.rd_data = {22'h00_0000, r.data_pol};
        ADDR_EN_POL:   s.rd_data = {14'h0000, r.en_pol};
        ADDR_CELL_ST:  s.rd_data = {14'h0000, r.cell_q};
        ADDR_INP_ST:   s.rd_data = {12'h000, r.pin_q, r.ded_q};
        default:       s.rd_data = 32'h0000_0000;
      endcase
    end

    // Dedicated input group capture
    if (ded_mode == IN_LATCH) begin
      if (input_capture_clock_in) begin
        s.ded_q = ded_in;
      end
    end else if (ded_mode == IN_REG) begin
      if (input_capture_clock_rise) begin
        s.ded_q = ded_in;
      end
    end
    s.ded_out = (ded_mode == IN_LATCH || ded_mode == IN_REG) ? s.ded_q : ded_in;

    // Pin input group capture; this is the second feedback path of each pin
    if (pin_mode == IN_LATCH) begin
      if (input_capture_clock_in) begin
        s.pin_q = pin_in;
      end
    end else if (pin_mode == IN_REG) begin
      if (input_capture_clock_rise) begin
        s.pin_q = pin_in;
      end
    end
    s.pin_cell_out = (pin_mode == IN_LATCH || pin_mode == IN_REG) ? s.pin_q : pin_in;

    // Power-up clear: output and buried cells ignore all clocks until the time has run out
    if (!r.pu_done) begin
      if (r.pu_cnt == 14'(POWERUP_CYCLES - 1)) begin
        s.pu_done = 1'b1;
      end else begin
        s.pu_cnt = r.pu_cnt + 14'h0001;
      end
    end

    // Output and buried cells, each with its own mode
    for (int i = 0; i < N_CELL; i++) begin
      md = {r.clk_src[i], r.bypass[i]};
      if (!r.pu_done || reset_term_in) begin
        s.cell_q[i] = 1'b0;
      end else if (md == 2'h2) begin
        if (shared_output_clock_rise && e_term[i]) begin
          s.cell_q[i] = d_term[i];
        end
      end else if (md == 2'h0) begin
        if (e_rise[i]) begin
          s.cell_q[i] = d_term[i];
        end
      end
      // Code 11 is not a legal mode and behaves as combinational
      s.fb[i] = r.bypass[i] ? d_term[i] : s.cell_q[i];
    end

    // Only the first ten cells reach pins, through an inverting buffer
    s.pin_data = ~s.fb[9:0];
    s.pin_oe_b = ~oe_term_in;
  end

  // Single state register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '{in_cfg: RST_IN_CFG, clk_src: RST_CLK_SRC, bypass: RST_BYPASS,
             data_pol: RST_DATA_POL, en_pol: RST_EN_POL,
             pin_data: 10'h3FF, pin_oe_b: 10'h3FF, default: '0};
    end else begin
      r <= s;
    end
  end

  // Outputs straight from the state flops; buried cells show only on feedback and in the cell status read
  assign rd_data_out              = r.rd_data;
  assign pin_out                  = r.pin_data;
  assign pin_oe_b_out             = r.pin_oe_b;
  assign dedicated_input_cell_out = r.ded_out;
  assign pin_input_cell_out       = r.pin_cell_out;
  assign cell_fb_out              = r.fb;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_input_capture_clock_rise_reg;
    (ded_mode == IN_REG) && input_capture_clock_rise;
  endsequence

  a_ded_reg_capture: assert property (s_input_capture_clock_rise_reg |=> dedicated_input_cell_out == $past(ded_in))
    else $error("dedicated register missed the capture edge");
  a_ded_latch_hold: assert property ((ded_mode == IN_LATCH) && !input_capture_clock_in
    && $past(ded_mode == IN_LATCH) |=> $stable(dedicated_input_cell_out))
    else $error("dedicated latch changed while closed");
  a_pin_pass_thru: assert property ((pin_mode == IN_PASS) |=> pin_input_cell_out == $past(pin_in))
    else $error("pin input not passed through");
  a_pin_inverts: assert property (pin_out == ~cell_fb_out[9:0])
    else $error("pin output is not the inverse of its cell");
  a_oe_follows: assert property (##1 pin_oe_b_out == ~$past(oe_term_in))
    else $error("output enable not following its term");
  a_reset_clears: assert property (reset_term_in |=> r.cell_q == 18'h0_0000)
    else $error("reset term did not clear cell registers");
  a_powerup_clear: assert property (!r.pu_done |-> r.cell_q == 18'h0_0000)
    else $error("cell register set before power-up clear ended");

  // Dedicated group in pass mode shows the pin one cycle later
  a_ded_pass_thru: assert property ((ded_mode == IN_PASS) |=> dedicated_input_cell_out == $past(ded_in))
    else $error("dedicated input not passed through");

  // Pin group captures on the input clock rise when registered
  sequence s_pin_reg_rise;
    (pin_mode == IN_REG) && input_capture_clock_rise;
  endsequence
  a_pin_reg_capture: assert property (s_pin_reg_rise |=> pin_input_cell_out == $past(pin_in))
    else $error("pin register missed the capture edge");

  // An open pin latch is transparent; a closed one has no hold check, only the dedicated latch has one
  sequence s_pin_latch_open;
    (pin_mode == IN_LATCH) && input_capture_clock_in;
  endsequence
  a_pin_latch_open: assert property (s_pin_latch_open |=> pin_input_cell_out == $past(pin_in))
    else $error("open pin latch did not pass its pin");

  for (genvar g = 0; g < N_CELL; g++) begin : g_chk
    sequence s_ce_load;
      r.pu_done && !reset_term_in && {r.clk_src[g], r.bypass[g]} == 2'h2 && shared_output_clock_rise && e_term[g];
    endsequence
    a_ce_load: assert property (s_ce_load |=> r.cell_q[g] == $past(d_term[g]))
      else $error("enabled register did not load on output clock");
    a_ce_hold: assert property ({r.clk_src[g], r.bypass[g]} == 2'h2 && !reset_term_in
      && !(shared_output_clock_rise && e_term[g]) |=> $stable(r.cell_q[g]))
      else $error("enabled register changed without enable");
    a_st_load: assert property (r.pu_done && !reset_term_in && {r.clk_src[g], r.bypass[g]} == 2'h0
      && e_rise[g] |=> r.cell_q[g] == $past(d_term[g]))
      else $error("sum-term register missed its clock edge");
    // Without a rise of its own term a sum-term register must hold
    a_st_hold: assert property (r.pu_done && !reset_term_in && {r.clk_src[g], r.bypass[g]} == 2'h0
      && !e_rise[g] |=> $stable(r.cell_q[g]))
      else $error("sum-term register changed without its clock edge");
    // A bypassed cell passes its data term straight to the feedback
    a_comb_follows: assert property (r.bypass[g] |=> cell_fb_out[g] == $past(d_term[g]))
      else $error("combinational cell not following its data term");
    // A registered cell feeds back its own register before the buffer
    a_reg_feedback: assert property (!r.bypass[g] |=> cell_fb_out[g] == r.cell_q[g])
      else $error("registered cell feedback differs from its register");
  end
endmodule

/* File: fcm_pkg.sv */
// Constants, register map and state type for the macrocell configuration block
package fcm_pkg;
  // Cell counts
  localparam int N_DED  = 10;
  localparam int N_PIN  = 10;
  localparam int N_BUR  = 8;
  localparam int N_CELL = 18;

  // Register bus widths
  localparam int AW = 8;
  localparam int DW = 32;

  // Register offsets
  localparam logic [7:0] ADDR_IN_CFG   = 8'h00;
  localparam logic [7:0] ADDR_CLK_SRC  = 8'h04;
  localparam logic [7:0] ADDR_BYPASS   = 8'h08;
  localparam logic [7:0] ADDR_DATA_POL = 8'h0C;
  localparam logic [7:0] ADDR_EN_POL   = 8'h10;
  localparam logic [7:0] ADDR_CELL_ST  = 8'h14;
  localparam logic [7:0] ADDR_INP_ST   = 8'h18;

  // Input config field positions: {pin hold, pin sync, ded hold, ded sync}
  localparam int IN_DED_SYNC = 0;
  localparam int IN_DED_HOLD = 1;
  localparam int IN_PIN_SYNC = 2;
  localparam int IN_PIN_HOLD = 3;

  // Reset values: inputs pass through, cells combinational, true polarity
  localparam logic [3:0]  RST_IN_CFG   = 4'hF;
  localparam logic [17:0] RST_CLK_SRC  = 18'h0_0000;
  localparam logic [17:0] RST_BYPASS   = 18'h3_FFFF;
  localparam logic [9:0]  RST_DATA_POL = 10'h000;
  localparam logic [17:0] RST_EN_POL   = 18'h0_0000;

  // Input group modes as {hold select, sync select}
  localparam logic [1:0] IN_PASS  = 2'h3;
  localparam logic [1:0] IN_REG   = 2'h2;
  localparam logic [1:0] IN_LATCH = 2'h0;

  // Power-up clear time
  localparam int RESET_TIME_NS  = 45000;
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int POWERUP_CYCLES = RESET_TIME_NS * 1000 / CLK_PERIOD_PS;

  // Whole state of the block
  typedef struct packed {
    logic [3:0]  in_cfg;
    logic [17:0] clk_src;
    logic [17:0] bypass;
    logic [9:0]  data_pol;
    logic [17:0] en_pol;
    logic [31:0] rd_data;
    logic        input_capture_clock_prev;
    logic        shared_output_clock_prev;
    logic [17:0] e_prev;
    logic [13:0] pu_cnt;
    logic        pu_done;
    logic [9:0]  ded_q;
    logic [9:0]  pin_q;
    logic [17:0] cell_q;
    logic [9:0]  ded_out;
    logic [9:0]  pin_cell_out;
    logic [17:0] fb;
    logic [9:0]  pin_data;
    logic [9:0]  pin_oe_b;
  } fcm_state_t;
endpackage

/* File: testbench.sv */
// Self-checking bench for the macrocell configuration block
`timescale 1ns/1ps
module testbench;
  import fcm_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, icap = 1'b0, ocap = 1'b0;
  logic rterm = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [17:0] dsum = 18'h0_0000, esum = 18'h0_0000, fb;
  logic [9:0] oe = 10'h000, ded = 10'h000, pin_lvl, pout, poe_b, dcell, pcell;
  logic [9:0] drv_en = 10'h3FF, drv_val = 10'h000;
  int num_errors = 0, checks_done = 0;

  fcm_macrocell #(.POWERUP_CYCLES(4)) fcm_macrocell_i (
    .clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat),
    .input_capture_clock_in(icap), .shared_output_clock_in(ocap),
    .data_sum_in(dsum), .enable_sum_in(esum), .reset_term_in(rterm), .oe_term_in(oe),
    .ded_in(ded), .pin_in(pin_lvl), .pin_out(pout), .pin_oe_b_out(poe_b),
    .dedicated_input_cell_out(dcell), .pin_input_cell_out(pcell), .cell_fb_out(fb));
  fcm_board fcm_board_i (.dev_pin_in(pout), .dev_oe_b_in(poe_b), .drv_en_in(drv_en),
    .drv_val_in(drv_val), .pin_lvl_out(pin_lvl));

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle write; an edge passes before the strobe may rise again
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdat <= d; wr_en <= 1'b1;
    cyc(1);
    wr_en <= 1'b0;
    cyc(1);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a; rd_en <= 1'b1;
    cyc(1);
    rd_en <= 1'b0;
    #1 chk(rdat, exp);
    cyc(1);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic t_regs;
    rchk(ADDR_IN_CFG, 32'(RST_IN_CFG));
    rchk(ADDR_CLK_SRC, 32'(RST_CLK_SRC));
    rchk(ADDR_BYPASS, 32'(RST_BYPASS));
    rchk(ADDR_DATA_POL, 32'(RST_DATA_POL));
    rchk(ADDR_EN_POL, 32'(RST_EN_POL));
    rchk(ADDR_CELL_ST, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    $display("test regs done");
  endtask

  // Dedicated group registered, pin group latched, then both pass-through
  task automatic t_inputs;
    wr(ADDR_IN_CFG, {28'h000_0000, IN_LATCH, IN_REG});
    ded <= 10'h155; drv_val <= 10'h2AA; icap <= 1'b1;
    cyc(4);
    chk(32'(dcell), 32'h0000_0155);
    chk(32'(pcell), 32'h0000_02AA);
    ded <= 10'h0F0; drv_val <= 10'h00F;
    cyc(4);
    chk(32'(dcell), 32'h0000_0155);
    chk(32'(pcell), 32'h0000_000F);
    icap <= 1'b0;
    cyc(3);
    drv_val <= 10'h3C0;
    cyc(4);
    chk(32'(pcell), 32'h0000_000F);
    rchk(ADDR_INP_ST, 32'h0000_3D55);
    wr(ADDR_IN_CFG, 32'(RST_IN_CFG));
    cyc(3);
    chk(32'(dcell), 32'h0000_00F0);
    chk(32'(pcell), 32'h0000_03C0);
    $display("test inputs done");
  endtask

  // Cell 0 enabled register, cell 1 sum-term clocked, cell 2 inverted comb
  task automatic t_cells;
    dsum <= 18'h3_FFFF; esum <= 18'h0_0002; oe <= 10'h3FF;
    wr(ADDR_CLK_SRC, 32'h0000_0001);
    wr(ADDR_BYPASS, 32'h0003_FFFC);
    wr(ADDR_DATA_POL, 32'h0000_0004);
    wr(ADDR_EN_POL, 32'h0000_0002);
    rterm <= 1'b1;
    cyc(2);
    rterm <= 1'b0;
    cyc(3);
    chk(32'(fb), 32'h0003_FFF8);
    chk(32'(pout), 32'h0000_0007);
    ocap <= 1'b1;
    cyc(3);
    ocap <= 1'b0;
    cyc(3);
    chk(32'(fb), 32'h0003_FFF8);
    esum <= 18'h0_0001;
    cyc(3);
    ocap <= 1'b1;
    cyc(3);
    chk(32'(fb), 32'h0003_FFFB);
    rchk(ADDR_CELL_ST, 32'h0000_0003);
    chk(32'(pout), 32'h0000_0004);
    rterm <= 1'b1;
    cyc(3);
    chk(32'(fb), 32'h0003_FFF8);
    rterm <= 1'b0; ocap <= 1'b0;
    cyc(3);
    $display("test cells done");
  endtask

  // Pins released and driven again; internal feedback stays usable
  task automatic t_oe;
    oe <= 10'h000; drv_val <= 10'h155;
    cyc(4);
    chk(32'(poe_b), 32'h0000_03FF);
    chk(32'(fb), 32'h0003_FFF8);
    chk(32'(pcell), 32'h0000_0155);
    oe <= 10'h3FF;
    cyc(4);
    chk(32'(poe_b), 32'h0000_0000);
    chk(32'(pcell), 32'h0000_0007);
    $display("test oe done");
  endtask

  initial begin
    cyc(5);
    chk(32'(pout), 32'h0000_03FF);
    chk(32'(poe_b), 32'h0000_03FF);
    cyc(5);
    rst_b <= 1'b1;
    cyc(10);
    t_regs();
    t_inputs();
    t_cells();
    t_oe();
    complete_run();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
endmodule
